// ### core/cmtc_pkg.sv
// Shared constants and types of the CAN mailbox transmit control block
package cmtc_pkg;
  // Mailbox count and index width
  localparam int unsigned NMB = 4;
  localparam int unsigned IDXW = 2;
  localparam int unsigned IDW = 29;
  // Mailbox command codes
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_INACTIVE = 4'h8;
  localparam logic [3:0] CODE_ABORT = 4'h9;
  localparam logic [3:0] CODE_TX = 4'hc;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CLEAR = 12'h008;
  localparam logic [11:0] OFF_IRQ_EN = 12'h00c;
  localparam logic [11:0] OFF_TXSTAT = 12'h010;
  // Mailbox window: 0x40 + 0x10 * index, word select below
  localparam logic [5:0] MB_REGION = 6'h01;
  localparam logic [1:0] MB_WORD_CS = 2'h0;
  localparam logic [1:0] MB_WORD_ID = 2'h1;
  localparam logic [1:0] MB_WORD_DATA = 2'h2;
  // Field positions
  localparam int unsigned CS_CODE_LSB = 24;
  localparam int unsigned CS_DLC_LSB = 16;
  localparam int unsigned CTRL_AEN_BIT = 0;
  localparam int unsigned TXSTAT_IDX_LSB = 1;
  // Reset values
  localparam logic [3:0] RST_CODE = 4'h0;
  localparam logic RST_AEN = 1'b0;
  localparam logic [NMB-1:0] RST_FLAGS = 4'h0;
  localparam logic [NMB-1:0] RST_MASK = 4'h0;
  // Transmit sequencer states
  typedef enum logic {ST_IDLE, ST_SEND} cmtc_st_t;
endpackage

// ### core/cmtc_irq.sv
// Sticky completion flags, write-one-to-clear, enable mask and interrupt line
`timescale 1ns/100ps
`default_nettype none
module cmtc_irq (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Event pulses, one bit per mailbox
  input wire logic [cmtc_pkg::NMB-1:0] set,
  // Software clear and mask writes
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [cmtc_pkg::NMB-1:0] wdata,
  // State and interrupt
  output logic [cmtc_pkg::NMB-1:0] flags,
  output logic [cmtc_pkg::NMB-1:0] mask,
  output logic irq
);
  logic [cmtc_pkg::NMB-1:0] flags_r, flags_nxt; // Sticky done flags
  logic [cmtc_pkg::NMB-1:0] mask_r, mask_nxt; // Interrupt mask
  logic irq_r, irq_nxt; // Registered interrupt level

  // Set beats clear so a completion in the clear cycle survives
  always_comb begin
    flags_nxt = clr_wr ? (flags_r & ~wdata) : flags_r;
    flags_nxt = flags_nxt | set;
    mask_nxt = en_wr ? wdata : mask_r;
    irq_nxt = |(flags_nxt & mask_nxt);
  end

  // Register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= cmtc_pkg::RST_FLAGS;
      mask_r <= cmtc_pkg::RST_MASK;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign flags = flags_r;
  assign mask = mask_r;
  assign irq = irq_r;

  // A completion on an enabled mailbox raises the line next cycle
  property p_irq_raise;
    @(posedge hclk) disable iff (!hresetn)
      (|(set & mask_r)) && !en_wr |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");
endmodule
`default_nettype wire

// ### core/cmtc_scan.sv
// Arbitration scan: walks the mailboxes one per cycle, lowest identifier wins
`timescale 1ns/100ps
`default_nettype none
module cmtc_scan (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic start,
  // Mailbox contents
  input wire logic [cmtc_pkg::NMB-1:0][3:0] codes,
  input wire logic [cmtc_pkg::NMB-1:0][cmtc_pkg::IDW-1:0] ids,
  // Result
  output logic busy,
  output logic done,
  output logic found,
  output logic [cmtc_pkg::IDXW-1:0] win
);
  logic busy_r, busy_nxt; // Walk in progress
  logic done_r, done_nxt; // Result pulse
  logic found_r, found_nxt; // Some mailbox holds the transmit code
  logic [cmtc_pkg::IDXW-1:0] idx_r, idx_nxt; // Mailbox under scan
  logic [cmtc_pkg::IDXW-1:0] win_r, win_nxt; // Best so far
  logic [cmtc_pkg::IDW-1:0] best_r, best_nxt; // Best identifier so far

  // Each code is sampled when its slot comes up; a later change is the
  // caller's business to catch with a rescan
  always_comb begin
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    found_nxt = found_r;
    idx_nxt = idx_r;
    win_nxt = win_r;
    best_nxt = best_r;
    if (start) begin
      busy_nxt = 1'b1;
      found_nxt = 1'b0;
      idx_nxt = '0;
    end else if (busy_r) begin
      if (codes[idx_r] == cmtc_pkg::CODE_TX && (!found_r || ids[idx_r] < best_r)) begin
        found_nxt = 1'b1;
        win_nxt = idx_r;
        best_nxt = ids[idx_r];
      end
      idx_nxt = idx_r + 1'b1;
      if (idx_r == cmtc_pkg::IDXW'(cmtc_pkg::NMB - 1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      found_r <= 1'b0;
      idx_r <= '0;
      win_r <= '0;
      best_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      found_r <= found_nxt;
      idx_r <= idx_nxt;
      win_r <= win_nxt;
      best_r <= best_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign found = found_r;
  assign win = win_r;
endmodule
`default_nettype wire

// ### core/cmtc_top.sv
// CAN mailbox transmit control: AHB-Lite registers, scheduling, abort, interrupt
`timescale 1ns/100ps
`default_nettype none
module cmtc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // CAN bit engine side
  input wire logic bus_idle,
  input wire logic rx_frame_start,
  input wire logic tx_done,
  input wire logic tx_lost,
  output logic tx_req,
  output logic [cmtc_pkg::IDW-1:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [31:0] tx_data,
  // Interrupt
  output logic irq
);
  localparam int unsigned N = cmtc_pkg::NMB;

  // Bus slave state
  logic wr_pend_r, wr_pend_nxt; // Write data phase open
  logic rd_pend_r, rd_pend_nxt; // Read wait state open
  logic [11:0] addr_r, addr_nxt; // Latched address
  logic [31:0] hrdata_r, hrdata_nxt; // Read data flop
  // Mailbox storage
  logic [N-1:0][3:0] code_r, code_nxt;
  logic [N-1:0][3:0] dlc_r, dlc_nxt;
  logic [N-1:0][cmtc_pkg::IDW-1:0] id_r, id_nxt;
  logic [N-1:0][31:0] data_r, data_nxt;
  logic [N-1:0] abort_pend_r, abort_pend_nxt; // Abort waits on frame in flight
  logic aen_r, aen_nxt; // abort_enable_setting
  // Sequencer state
  cmtc_pkg::cmtc_st_t st_r, st_nxt;
  logic rescan_r, rescan_nxt; // Scan result is stale
  logic [cmtc_pkg::IDXW-1:0] cur_r, cur_nxt; // Mailbox being sent
  logic tx_req_r, tx_req_nxt;
  logic [cmtc_pkg::IDW-1:0] tx_id_r, tx_id_nxt;
  logic [3:0] tx_dlc_r, tx_dlc_nxt;
  logic [31:0] tx_data_r, tx_data_nxt;
  // Decode and glue
  logic accept; // Address phase taken
  logic mb_hit; // Mailbox window selected
  logic [cmtc_pkg::IDXW-1:0] mb_idx;
  logic [1:0] mb_word;
  logic cs_wr; // Control word write this cycle
  logic [N-1:0] cs_onehot;
  logic [3:0] wr_code;
  logic any_tx;
  logic [N-1:0] flag_set; // Completion events
  logic [N-1:0] flags, mask;
  logic scan_start, scan_busy, scan_done, scan_found;
  logic [cmtc_pkg::IDXW-1:0] scan_win;
  logic launch;

  // Address and strobe decode; reads get one wait so data is always fresh
  assign accept = hsel && hready && htrans[1];
  assign mb_hit = addr_r[11:6] == cmtc_pkg::MB_REGION;
  assign mb_idx = addr_r[5:4];
  assign mb_word = addr_r[3:2];
  assign cs_wr = wr_pend_r && mb_hit && mb_word == cmtc_pkg::MB_WORD_CS;
  assign cs_onehot = cs_wr ? (N'(1) << mb_idx) : '0;
  assign wr_code = hwdata[cmtc_pkg::CS_CODE_LSB +: 4];
  assign hreadyout = !rd_pend_r;
  assign hresp = 1'b0;

  // Bus slave phases; hsize is ignored as only whole words are used
  always_comb begin
    wr_pend_nxt = accept && hwrite;
    rd_pend_nxt = accept && !hwrite;
    addr_nxt = accept ? haddr : addr_r;
    hrdata_nxt = hrdata_r;
    if (rd_pend_r) begin
      hrdata_nxt = '0;
      if (mb_hit) begin
        unique case (mb_word)
          cmtc_pkg::MB_WORD_CS: begin
            hrdata_nxt[cmtc_pkg::CS_CODE_LSB +: 4] = code_r[mb_idx];
            hrdata_nxt[cmtc_pkg::CS_DLC_LSB +: 4] = dlc_r[mb_idx];
          end
          cmtc_pkg::MB_WORD_ID: hrdata_nxt[cmtc_pkg::IDW-1:0] = id_r[mb_idx];
          cmtc_pkg::MB_WORD_DATA: hrdata_nxt = data_r[mb_idx];
          default: hrdata_nxt = '0;
        endcase
      end else begin
        unique case (addr_r)
          cmtc_pkg::OFF_CTRL: hrdata_nxt[cmtc_pkg::CTRL_AEN_BIT] = aen_r;
          cmtc_pkg::OFF_STATUS: hrdata_nxt[N-1:0] = flags;
          cmtc_pkg::OFF_IRQ_EN: hrdata_nxt[N-1:0] = mask;
          cmtc_pkg::OFF_TXSTAT: begin
            hrdata_nxt[0] = tx_req_r;
            hrdata_nxt[cmtc_pkg::TXSTAT_IDX_LSB +: cmtc_pkg::IDXW] = cur_r;
          end
          default: hrdata_nxt = '0; // Unmapped and clear register read zero
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= '0;
      hrdata_r <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r <= addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end
  assign hrdata = hrdata_r;

  // Mailbox contents, abort handling and completion events
  always_comb begin
    code_nxt = code_r;
    dlc_nxt = dlc_r;
    id_nxt = id_r;
    data_nxt = data_r;
    abort_pend_nxt = abort_pend_r;
    aen_nxt = aen_r;
    flag_set = '0;
    // Frame outcome for the mailbox in flight
    if (st_r == cmtc_pkg::ST_SEND && tx_done) begin
      if (code_r[cur_r] == cmtc_pkg::CODE_TX) begin
        code_nxt[cur_r] = cmtc_pkg::CODE_INACTIVE;
        flag_set[cur_r] = 1'b1; // Sent; code reads back inactive
      end
      abort_pend_nxt[cur_r] = 1'b0;
    end else if (st_r == cmtc_pkg::ST_SEND && tx_lost && abort_pend_r[cur_r]) begin
      code_nxt[cur_r] = cmtc_pkg::CODE_ABORT;
      flag_set[cur_r] = 1'b1; // Lost arbitration, abort takes effect
      abort_pend_nxt[cur_r] = 1'b0;
    end
    // Software writes override the stored word afterwards
    if (wr_pend_r && !mb_hit && addr_r == cmtc_pkg::OFF_CTRL) begin
      aen_nxt = hwdata[cmtc_pkg::CTRL_AEN_BIT];
    end
    if (wr_pend_r && mb_hit && mb_word == cmtc_pkg::MB_WORD_ID) begin
      id_nxt[mb_idx] = hwdata[cmtc_pkg::IDW-1:0];
    end
    if (wr_pend_r && mb_hit && mb_word == cmtc_pkg::MB_WORD_DATA) begin
      data_nxt[mb_idx] = hwdata;
    end
    if (cs_wr) begin
      dlc_nxt[mb_idx] = hwdata[cmtc_pkg::CS_DLC_LSB +: 4];
      if (wr_code == cmtc_pkg::CODE_ABORT && aen_r) begin
        if (code_r[mb_idx] == cmtc_pkg::CODE_TX) begin
          if (st_r == cmtc_pkg::ST_SEND && cur_r == mb_idx) begin
            abort_pend_nxt[mb_idx] = 1'b1; // Frame on the wire decides
          end else begin
            code_nxt[mb_idx] = cmtc_pkg::CODE_ABORT;
            flag_set[mb_idx] = 1'b1; // Cancelled before it left
          end
        end
      end else if (wr_code == cmtc_pkg::CODE_ABORT) begin
        code_nxt[mb_idx] = cmtc_pkg::CODE_INACTIVE; // Silent deactivation
        abort_pend_nxt[mb_idx] = 1'b0;
      end else begin
        code_nxt[mb_idx] = wr_code; // Pending frame may still go, unflagged
        abort_pend_nxt[mb_idx] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_r <= {N{cmtc_pkg::RST_CODE}};
      dlc_r <= '0;
      id_r <= '0;
      data_r <= '0;
      abort_pend_r <= '0;
      aen_r <= cmtc_pkg::RST_AEN;
    end else begin
      code_r <= code_nxt;
      dlc_r <= dlc_nxt;
      id_r <= id_nxt;
      data_r <= data_nxt;
      abort_pend_r <= abort_pend_nxt;
      aen_r <= aen_nxt;
    end
  end

  // Scheduling: any control write or frame start marks the scan stale, so a
  // code written just after its slot is scanned is never missed
  always_comb begin
    any_tx = 1'b0;
    for (int i = 0; i < N; i++) begin
      any_tx = any_tx | (code_r[i] == cmtc_pkg::CODE_TX);
    end
  end
  assign scan_start = !scan_busy && !scan_done
    && (rescan_r || (st_r == cmtc_pkg::ST_IDLE && bus_idle && any_tx));
  // A control write in the launch cycle may abort or replace the winner, so
  // it defers the launch to the rescan it triggers
  assign launch = st_r == cmtc_pkg::ST_IDLE && scan_done && scan_found && !rescan_r
    && !cs_wr && bus_idle && code_r[scan_win] == cmtc_pkg::CODE_TX;

  always_comb begin
    // Set wins over the clear taken by a starting scan
    rescan_nxt = (rescan_r && !scan_start) || cs_wr || rx_frame_start;
    st_nxt = st_r;
    cur_nxt = cur_r;
    tx_req_nxt = tx_req_r;
    tx_id_nxt = tx_id_r;
    tx_dlc_nxt = tx_dlc_r;
    tx_data_nxt = tx_data_r;
    unique case (st_r)
      cmtc_pkg::ST_IDLE: begin
        if (launch) begin
          st_nxt = cmtc_pkg::ST_SEND;
          cur_nxt = scan_win;
          tx_req_nxt = 1'b1;
          tx_id_nxt = id_r[scan_win];
          tx_dlc_nxt = dlc_r[scan_win];
          tx_data_nxt = data_r[scan_win];
        end
      end
      cmtc_pkg::ST_SEND: begin
        if (tx_done || tx_lost) begin
          st_nxt = cmtc_pkg::ST_IDLE;
          tx_req_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= cmtc_pkg::ST_IDLE;
      rescan_r <= 1'b0;
      cur_r <= '0;
      tx_req_r <= 1'b0;
      tx_id_r <= '0;
      tx_dlc_r <= '0;
      tx_data_r <= '0;
    end else begin
      st_r <= st_nxt;
      rescan_r <= rescan_nxt;
      cur_r <= cur_nxt;
      tx_req_r <= tx_req_nxt;
      tx_id_r <= tx_id_nxt;
      tx_dlc_r <= tx_dlc_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end
  assign tx_req = tx_req_r;
  assign tx_id = tx_id_r;
  assign tx_dlc = tx_dlc_r;
  assign tx_data = tx_data_r;

  // Arbitration scan engine
  cmtc_scan u_scan (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(scan_start),
    .codes(code_r),
    .ids(id_r),
    .busy(scan_busy),
    .done(scan_done),
    .found(scan_found),
    .win(scan_win)
  );

  // Done flags and interrupt
  cmtc_irq u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(flag_set),
    .clr_wr(wr_pend_r && !mb_hit && addr_r == cmtc_pkg::OFF_CLEAR),
    .en_wr(wr_pend_r && !mb_hit && addr_r == cmtc_pkg::OFF_IRQ_EN),
    .wdata(hwdata[N-1:0]),
    .flags(flags),
    .mask(mask),
    .irq(irq)
  );

  // Checks
  sequence s_scan_soon;
    ##[1:8] scan_start;
  endsequence
  property p_tx_write;
    @(posedge hclk) disable iff (!hresetn)
      cs_wr && wr_code == cmtc_pkg::CODE_TX |=> rescan_r;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx code write lost");
  property p_cs_rescan;
    @(posedge hclk) disable iff (!hresetn)
      cs_wr |-> s_scan_soon;
  endproperty
  a_cs_rescan: assert property (p_cs_rescan) else $error("no rescan on write");
  property p_rx_rescan;
    @(posedge hclk) disable iff (!hresetn)
      rx_frame_start |-> s_scan_soon;
  endproperty
  a_rx_rescan: assert property (p_rx_rescan) else $error("no rescan on rx");
  property p_idle_send;
    @(posedge hclk) disable iff (!hresetn)
      st_r == cmtc_pkg::ST_IDLE && bus_idle && any_tx && !scan_busy && !rescan_r
      |-> ##[1:8] (tx_req || !bus_idle || !any_tx || rescan_r);
  endproperty
  a_idle_send: assert property (p_idle_send) else $error("pending frame not sent");
  property p_abort_flag;
    @(posedge hclk) disable iff (!hresetn)
      cs_wr && aen_r && wr_code == cmtc_pkg::CODE_ABORT
      && code_r[mb_idx] == cmtc_pkg::CODE_TX && !(st_r == cmtc_pkg::ST_SEND && cur_r == mb_idx)
      |=> ((flags & $past(cs_onehot)) != '0) && !tx_req;
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged");
  property p_no_aen;
    @(posedge hclk) disable iff (!hresetn)
      cs_wr && !aen_r && (wr_code == cmtc_pkg::CODE_ABORT || wr_code == cmtc_pkg::CODE_INACTIVE)
      |-> (flag_set & cs_onehot) == '0 ##1 code_r[$past(mb_idx)] == cmtc_pkg::CODE_INACTIVE;
  endproperty
  a_no_aen: assert property (p_no_aen) else $error("deactivation misbehaved");
endmodule
`default_nettype wire

// ### verification/cmtc_can_node.sv
// Far-side CAN bit engine model: answers launches and injects foreign frames
`timescale 1ns/100ps
`default_nettype none
module cmtc_can_node (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Controller side
  input wire logic tx_req,
  output logic bus_idle,
  output logic rx_frame_start,
  output logic tx_done,
  output logic tx_lost,
  // Bench steering
  input wire logic quiet,
  input wire logic inject,
  input wire logic lose,
  input wire logic [3:0] delay
);
  int wait_n; // Cycles spent on the current frame
  int busy_n; // Remaining cycles of a foreign frame
  // Idle only when nobody, the controller included, is on the bus
  assign bus_idle = quiet && !tx_req && busy_n == 0;
  // One answer per launch, given only while the request stands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_n <= 0;
      busy_n <= 0;
      tx_done <= 1'b0;
      tx_lost <= 1'b0;
      rx_frame_start <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tx_lost <= 1'b0;
      // Foreign frame start, then the bus stays busy for a while
      rx_frame_start <= inject;
      busy_n <= inject ? 8 : (busy_n > 0 ? busy_n - 1 : 0);
      if (tx_req && !tx_done && !tx_lost) begin
        wait_n <= wait_n + 1;
        if (wait_n >= delay) begin
          // Lost only when the bench asks, so done and lost both occur
          tx_done <= !lose;
          tx_lost <= lose;
          wait_n <= 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the CAN mailbox transmit control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  // Bus and pin signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd, tx_data;
  logic bus_idle, rx_frame_start, tx_done, tx_lost, tx_req, req_q;
  logic [cmtc_pkg::IDW-1:0] tx_id;
  logic [3:0] tx_dlc, delay;
  logic quiet, inject, lose;
  // Reference model state and counters
  int failures, compares, seed, aen, flags, mask, fly, last, launched, sent;
  int abt; // Mailbox whose abort waits on the frame in flight, -1 if none
  int code[4], dlc[4], id[4], dat[4];
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  cmtc_top cmtc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_idle(bus_idle),
    .rx_frame_start(rx_frame_start), .tx_done(tx_done), .tx_lost(tx_lost),
    .tx_req(tx_req), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .irq(irq));
  cmtc_can_node cmtc_can_node_inst (.hclk(hclk), .hresetn(hresetn), .tx_req(tx_req),
    .bus_idle(bus_idle), .rx_frame_start(rx_frame_start), .tx_done(tx_done),
    .tx_lost(tx_lost), .quiet(quiet), .inject(inject), .lose(lose), .delay(delay));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Byte address of word w of mailbox m
  function automatic logic [11:0] mb(input int m, input int w);
    return 12'(64 + 16 * m + 4 * w);
  endfunction
  // Pending mailbox with the lowest identifier, lowest index on ties
  function automatic int win();
    int w;
    w = -1;
    for (int m = 0; m < 4; m++)
      if (code[m] == 12 && (w < 0 || id[m] < id[w])) w = m;
    return w;
  endfunction
  // Expected read value; unmapped places read zero
  function automatic logic [31:0] mdl_rd(input logic [11:0] a);
    int m;
    m = (a - 12'h040) >> 4;
    if (a == cmtc_pkg::OFF_CTRL) return 32'(aen);
    if (a == cmtc_pkg::OFF_STATUS) return 32'(flags);
    if (a == cmtc_pkg::OFF_IRQ_EN) return 32'(mask);
    if (a == cmtc_pkg::OFF_TXSTAT) return 32'(last * 2 + (fly >= 0));
    if (a < 12'h040 || a >= 12'h080) return 32'h0;
    case (a[3:2])
      2'h0: return {4'h0, 4'(code[m]), 4'h0, 4'(dlc[m]), 16'h0};
      2'h1: return 32'(id[m]);
      2'h2: return 32'(dat[m]);
      default: return 32'h0;
    endcase
  endfunction
  // Model side effects of a register write
  task automatic mdl_wr(input logic [11:0] a, input logic [31:0] d);
    int m;
    int c;
    m = (a - 12'h040) >> 4;
    c = d[27:24];
    if (a == cmtc_pkg::OFF_CTRL) aen = d[0];
    if (a == cmtc_pkg::OFF_CLEAR) flags &= ~d[3:0];
    if (a == cmtc_pkg::OFF_IRQ_EN) mask = d[3:0];
    if (a >= 12'h040 && a < 12'h080 && a[3:2] == 2'h1) id[m] = d[28:0];
    if (a >= 12'h040 && a < 12'h080 && a[3:2] == 2'h2) dat[m] = d;
    if (a >= 12'h040 && a < 12'h080 && a[3:2] == 2'h0) begin
      dlc[m] = d[19:16];
      // Abort takes effect at once only when not already on the wire
      if (c == 9 && aen == 1) begin
        if (code[m] == 12 && fly != m) begin
          code[m] = 9;
          flags |= 1 << m;
        end else if (code[m] == 12) begin
          abt = m; // On the wire: a lost arbitration becomes the abort
        end
      end else begin
        code[m] = (c == 9) ? 8 : c;
        if (abt == m) abt = -1;
      end
    end
  endtask
  // One AHB-Lite single transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (wr) mdl_wr(a, d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    // Wait states are honoured: only the watchdog ends a stuck transfer
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
    `CHK(n < 40, 1'b1)
  endtask
  // Read every mapped word plus unmapped holes, then the interrupt line
  task automatic check_all();
    for (int a = 0; a < 'h80; a += 4) begin
      if (a >= 'h18 && a < 'h40) continue;
      bus(1'b0, 12'(a), 32'h0);
      `CHK(rd, mdl_rd(12'(a))) // Readback
    end
    `CHK(irq, 1'((flags & mask) != 0))
  endtask
  // Bounded wait for a launch (0) or completion (1) count
  task automatic wait_cnt(input int which, input int k);
    int n;
    n = 0;
    while ((which ? sent : launched) < k && n < 400) begin
      @(posedge hclk);
      n++;
    end
    `CHK(n < 400, 1'b1)
    if (n >= 400) close_out();
  endtask
  // Software preparation of a mailbox, then the double kick of mailbox 0
  task automatic prep(input int m);
    bus(1'b1, cmtc_pkg::OFF_CLEAR, 32'(1 << m));
    bus(1'b1, mb(m, 0), 32'h0);
    bus(1'b1, mb(m, 1), 32'($random(seed) & 32'h1fffffff));
    bus(1'b1, mb(m, 2), $random(seed));
    bus(1'b1, mb(m, 0), {4'h0, cmtc_pkg::CODE_TX, 4'h0, 4'($random(seed)), 16'h0});
    bus(1'b1, mb(0, 0), {4'h0, cmtc_pkg::CODE_INACTIVE, 24'h0});
    bus(1'b1, mb(0, 0), {4'h0, cmtc_pkg::CODE_INACTIVE, 24'h0});
  endtask
  // Model of launch and completion; each launch is compared
  always @(posedge hclk) begin
    if (hresetn && tx_req && !req_q) begin
      fly = win();
      `CHK(fly >= 0, 1'b1)
      if (fly < 0) fly = 0;
      last = fly;
      launched++;
      `CHK(tx_id, 29'(id[fly]))
      `CHK(tx_dlc, 4'(dlc[fly]))
      `CHK(tx_data, 32'(dat[fly]))
    end
    if (tx_req && (tx_done || tx_lost)) begin
      // A plain lost arbitration leaves the mailbox pending for a retry
      if (code[fly] == 12 && (tx_done || abt == fly)) begin
        code[fly] = tx_done ? 8 : 9;
        flags |= 1 << fly;
      end
      abt = -1;
      fly = -1;
      sent++;
    end
    req_q = tx_req;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge hclk);
    failures++;
    close_out();
  end
  // Main sequence
  initial begin
    seed = 6929;
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 12'h000;
    hwrite = 1'b0;
    hwdata = 32'h0;
    {quiet, inject, lose, delay, req_q} = {3'b100, 4'h0, 1'b0};
    {failures, compares, aen, flags, mask, last, launched, sent} = '0;
    fly = -1;
    abt = -1;
    for (int m = 0; m < 4; m++) {code[m], dlc[m], id[m], dat[m]} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped and read-only places
    bus(1'b1, 12'h014, $random(seed));
    bus(1'b1, cmtc_pkg::OFF_STATUS, 32'hf);
    check_all();
    bus(1'b1, mb(0, 0), {4'h0, cmtc_pkg::CODE_INACTIVE, 24'h0});
    // Single sends, mailbox 1 to 3 in turn, random mask and answer delay
    for (int k = 1; k <= 6; k++) begin
      delay <= 4'($random(seed));
      bus(1'b1, cmtc_pkg::OFF_IRQ_EN, $random(seed));
      prep(1 + k % 3);
      wait_cnt(1, k);
      check_all();
    end
    // Transmit code landing at each point of a running scan
    for (int d = 0; d < 8; d++) begin
      bus(1'b1, mb(1, 0), 32'h0);
      repeat (d) @(posedge hclk);
      bus(1'b1, mb(2, 0), {4'h0, cmtc_pkg::CODE_TX, 24'h0});
      wait_cnt(1, sent + 1);
    end
    check_all();
    // Queue three while busy, abort or drop one, then release the bus
    for (int a = 0; a < 2; a++) begin
      quiet <= 1'b0;
      bus(1'b1, cmtc_pkg::OFF_CTRL, 32'(a ^ 1));
      prep(1);
      prep(2);
      prep(3);
      bus(1'b1, mb(2, 0), {4'h0, cmtc_pkg::CODE_ABORT, 24'h0});
      check_all();
      quiet <= 1'b1;
      wait_cnt(1, sent + 2);
      check_all();
    end
    // Foreign frame start right after an activation
    quiet <= 1'b0;
    prep(1);
    inject <= 1'b1;
    @(posedge hclk);
    inject <= 1'b0;
    quiet <= 1'b1;
    wait_cnt(1, sent + 1);
    // Abort or drop while the frame is on the wire
    delay <= 4'hf;
    for (int a = 0; a < 2; a++) begin
      lose <= (a == 0) ? 1'($random(seed)) : 1'b0;
      bus(1'b1, cmtc_pkg::OFF_CTRL, 32'(a ^ 1));
      prep(3);
      wait_cnt(0, launched + 1);
      bus(1'b1, mb(3, 0), {4'h0, a ? 4'h8 : cmtc_pkg::CODE_ABORT, 24'h0});
      wait_cnt(1, sent + 1);
      check_all();
    end
    close_out();
  end
endmodule
`default_nettype wire
